/* common/cadc_params.svh */
// Purpose: offsets, fields, marker values and timing counts of the cell ADC control
// Assumes: 25 MHz clock, 32-bit AXI4-Lite register bus
// Notes: how it works is listed below
`ifndef CADC_PARAMS_SVH
`define CADC_PARAMS_SVH
`define CADC_OFF_TRIG 12'h000
`define CADC_OFF_DELAY 12'h004
`define CADC_OFF_SEQCFG 12'h008
`define CADC_OFF_CHEN 12'h00C
`define CADC_OFF_STATUS 12'h010
`define CADC_OFF_COUNT 12'h014
`define CADC_RES_BASE 12'h040
`define CADC_RES_STRIDE 12'h020
`define CADC_SLOT_SHIFT 5
`define CADC_B_H 3'h0
`define CADC_B_L 3'h1
`define CADC_B_HU 3'h2
`define CADC_B_MU 3'h3
`define CADC_B_LU 3'h4
`define CADC_TRIG_BIT 0
`define CADC_CONT_BIT 0
`define CADC_INT_LSB 4
`define CADC_BUSY_BIT 0
`define CADC_RDY_BIT 1
`define CADC_MARK16 16'h8000
`define CADC_MARK24 24'h800000
`define CADC_CLK_NS 40
`define CADC_DLY_STEP_NS 1000
`define CADC_INT_STEP_NS 100000
`define CADC_DLY_STEP_CYC ((`CADC_DLY_STEP_NS + `CADC_CLK_NS - 1) / `CADC_CLK_NS)
`define CADC_INT_STEP_CYC ((`CADC_INT_STEP_NS + `CADC_CLK_NS - 1) / `CADC_CLK_NS)
`define CADC_TMR_W 16
`endif

/* common/cadc_pkg.sv */
// Purpose: shared types of the cell ADC control
// Assumes: nothing beyond the params header
// Notes: response codes follow AXI encoding
package cadc_pkg;
   typedef enum logic [1:0] {CADC_IDLE, CADC_DELAY, CADC_RUN, CADC_WAIT} cadc_state_t;
   typedef enum logic [1:0] {CADC_OKAY, CADC_EXOKAY, CADC_SLVERR} cadc_resp_t;
endpackage

/* common/cadc_tmr_if.sv */
// Purpose: carries load, count and expiry between sequencer and timer
// Assumes: one owner drives load and count
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
`include "cadc_params.svh"
interface cadc_tmr_if;
   logic load;
   logic [`CADC_TMR_W-1:0] count;
   logic done;
   modport timer (input load, input count, output done);
   modport owner (output load, output count, input done);
endinterface

/* src/cadc_result_slot.sv */
// Purpose: one channel's result store with high-byte freeze
// Assumes: preload has priority over a write
// Notes: lower bytes are read from the frozen copy
`timescale 1ns/1ps
`include "cadc_params.svh"
module cadc_result_slot #(parameter int RAW_W = 24, parameter int COR_W = 16) (
   input wire logic i_clock,                // system clock
   input wire logic i_rst_n,                // synchronised reset
   input wire logic i_preload,              // trigger marker load
   input wire logic i_wr,                   // conversion done
   input wire logic [RAW_W-1:0] i_raw,      // uncorrected result
   input wire logic [COR_W-1:0] i_corr,     // corrected result
   input wire logic i_frz_c,                // corrected high byte read
   input wire logic i_frz_u,                // uncorrected high byte read
   output logic [RAW_W-1:0] o_raw,          // live uncorrected
   output logic [COR_W-1:0] o_corr,         // live corrected
   output logic [RAW_W-9:0] o_raw_lo,       // frozen middle and low
   output logic [COR_W-9:0] o_corr_lo       // frozen low
);
   import cadc_pkg::*;
   typedef struct packed {
      logic [RAW_W-1:0] raw;
      logic [COR_W-1:0] corr;
      logic [RAW_W-9:0] raw_lo;
      logic [COR_W-9:0] corr_lo;
   } cadc_slot_st_t;
   cadc_slot_st_t s_q, s_d;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   always_comb begin
      s_d = s_q;
      // Freeze takes the value whose high byte is being returned now
      if (i_frz_c) s_d.corr_lo = s_q.corr[COR_W-9:0];
      if (i_frz_u) s_d.raw_lo = s_q.raw[RAW_W-9:0];
      if (i_preload) begin
         s_d.raw = RAW_W'(`CADC_MARK24);
         s_d.corr = COR_W'(`CADC_MARK16);
         s_d.raw_lo = '0;
         s_d.corr_lo = '0;
      end else if (i_wr) begin
         s_d.raw = i_raw;
         s_d.corr = i_corr;
      end
   end
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) s_q <= '0;
      else s_q <= s_d;
   end
   assign o_raw = s_q.raw;
   assign o_corr = s_q.corr;
   assign o_raw_lo = s_q.raw_lo;
   assign o_corr_lo = s_q.corr_lo;
   a_preload_marker: assert property (i_preload |=> o_corr == COR_W'(`CADC_MARK16) && o_raw == RAW_W'(`CADC_MARK24)) else $error("marker not loaded");
   a_freeze_hold: assert property (!i_frz_c && !i_preload |=> $stable(o_corr_lo)) else $error("low byte moved without high read");
endmodule // cadc_result_slot

/* src/cadc_timer.sv */
// Purpose: one-shot countdown for start delay and continuous interval
// Assumes: a load restarts the count
// Notes: done pulses count+1 edges after the load edge
`timescale 1ns/1ps
`include "cadc_params.svh"
module cadc_timer (
   input wire logic i_clock, // system clock
   input wire logic i_rst_n, // synchronised reset
   cadc_tmr_if.timer bus     // load, count, done
);
   import cadc_pkg::*;
   typedef struct packed {
      logic [`CADC_TMR_W-1:0] cnt;
      logic run;
      logic done;
   } cadc_tmr_st_t;
   cadc_tmr_st_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (bus.load) begin
         s_d.cnt = bus.count;
         s_d.run = 1'b1;
      end else if (s_q.run && s_q.cnt == '0) begin
         s_d.run = 1'b0;
         s_d.done = 1'b1;
      end else if (s_q.run) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) s_q <= '0;
      else s_q <= s_d;
   end
   assign bus.done = s_q.done;
endmodule // cadc_timer

/* src/cadc_top.sv */
// Purpose: cell ADC conversion control with AXI4-Lite register access
// Assumes: converters pulse done per channel; die temperature ADC starts with them
// Notes: last slot holds die temperature
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "cadc_params.svh"
module cadc_top #(parameter int NCH = 6) (
   input wire logic i_clock,                 // 25 MHz clock
   input wire logic i_rst_n,                 // async reset, active low
   input wire logic i_axi_awvalid,           // write address valid
   output logic o_axi_awready,               // write address ready
   input wire logic [11:0] i_axi_awaddr,     // write byte address
   input wire logic i_axi_wvalid,            // write data valid
   output logic o_axi_wready,                // write data ready
   input wire logic [31:0] i_axi_wdata,      // write data
   input wire logic [3:0] i_axi_wstrb,       // byte enables
   output logic o_axi_bvalid,                // write response valid
   input wire logic i_axi_bready,            // write response ready
   output logic [1:0] o_axi_bresp,           // write response
   input wire logic i_axi_arvalid,           // read address valid
   output logic o_axi_arready,               // read address ready
   input wire logic [11:0] i_axi_araddr,     // read byte address
   output logic o_axi_rvalid,                // read data valid
   input wire logic i_axi_rready,            // read data ready
   output logic [31:0] o_axi_rdata,          // read data
   output logic [1:0] o_axi_rresp,           // read response
   input wire logic [NCH-1:0] i_ch_done,     // per channel done pulse
   input wire logic [NCH*24-1:0] i_ch_raw,   // uncorrected results
   input wire logic [NCH*16-1:0] i_ch_corr,  // corrected results
   input wire logic i_temp_done,             // die temperature done pulse
   input wire logic [15:0] i_temp_raw,       // raw sensor voltage
   output logic [NCH-1:0] o_level_shift_en,  // level shifter power
   output logic o_conv_start,                // start all converters
   output logic o_conv_abort,                // abort running conversion
   output logic [15:0] o_die_temp            // stored die temperature
);
   import cadc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic awfull;
      logic wfull;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic wstb0;
      logic awrdy;
      logic wrdy;
      logic bvalid;
      cadc_resp_t bresp;
      logic arrdy;
      logic rvalid;
      logic [31:0] rdata;
      cadc_resp_t rresp;
      logic go;
      logic [7:0] dly;
      logic cont;
      logic [3:0] intv;
      logic [NCH-1:0] chen;
      cadc_state_t state;
      logic cont_run;
      logic busy;
      logic ready;
      logic complete;
      logic [13:0] count;
      logic [NCH-1:0] donem;
      logic tdone;
      logic start;
      logic abort;
   } cadc_top_st_t;

   localparam logic [11:0] RES_END = 12'(`CADC_RES_BASE + (NCH + 1) * `CADC_RES_STRIDE);
   localparam logic [15:0] DLY_CYC = 16'(`CADC_DLY_STEP_CYC);
   localparam logic [15:0] INT_CYC = 16'(`CADC_INT_STEP_CYC);

   cadc_top_st_t s_q, s_d;
   logic rst_meta_q;
   logic rst_n;
   logic wr_fire;
   logic rd_acc;
   logic locked;
   logic all_done;
   logic [NCH-1:0] donem_nx;
   logic [31:0] rd_data;
   cadc_resp_t rd_resp;
   logic [11:0] rd_off;
   logic [6:0] rd_idx;
   logic [2:0] rd_byte;
   logic [NCH:0] frz_c;
   logic [NCH:0] frz_u;
   logic [23:0] sl_raw [NCH+1];
   logic [15:0] sl_corr [NCH+1];
   logic [15:0] sl_raw_lo [NCH+1];
   logic [7:0] sl_corr_lo [NCH+1];
   cadc_tmr_if tmr_bus();

   default clocking @(posedge i_clock); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   assign wr_fire = s_q.awfull && s_q.wfull && !s_q.bvalid;
   assign rd_acc = i_axi_arvalid && s_q.arrdy;
   // Only a running continuous sequence locks the interval and channel enables
   assign locked = s_q.cont_run && (s_q.state != CADC_IDLE);
   assign donem_nx = s_q.donem | (i_ch_done & s_q.chen);
   assign all_done = (donem_nx == s_q.chen) && (s_q.tdone || i_temp_done);

   ////////////////////////////////////////////////////////////////////////////
   // Read decode; a high byte read freezes the lower bytes of the same result
   always_comb begin
      rd_data = '0;
      rd_resp = CADC_SLVERR;
      frz_c = '0;
      frz_u = '0;
      rd_off = i_axi_araddr - `CADC_RES_BASE;
      rd_idx = 7'(rd_off >> `CADC_SLOT_SHIFT);
      rd_byte = rd_off[4:2];
      if (i_axi_araddr[1:0] != 2'h0) begin
         rd_resp = CADC_SLVERR;
      end else if (i_axi_araddr == `CADC_OFF_TRIG) begin
         rd_resp = CADC_OKAY;
      end else if (i_axi_araddr == `CADC_OFF_DELAY) begin
         rd_data[7:0] = s_q.dly;
         rd_resp = CADC_OKAY;
      end else if (i_axi_araddr == `CADC_OFF_SEQCFG) begin
         rd_data[`CADC_CONT_BIT] = s_q.cont;
         rd_data[`CADC_INT_LSB +: 4] = s_q.intv;
         rd_resp = CADC_OKAY;
      end else if (i_axi_araddr == `CADC_OFF_CHEN) begin
         rd_data[NCH-1:0] = s_q.chen;
         rd_resp = CADC_OKAY;
      end else if (i_axi_araddr == `CADC_OFF_STATUS) begin
         rd_data[`CADC_BUSY_BIT] = s_q.busy;
         rd_data[`CADC_RDY_BIT] = s_q.ready;
         rd_resp = CADC_OKAY;
      end else if (i_axi_araddr == `CADC_OFF_COUNT) begin
         rd_data[13:0] = s_q.count;
         rd_resp = CADC_OKAY;
      end else if (i_axi_araddr >= `CADC_RES_BASE && i_axi_araddr < RES_END) begin
         for (int i = 0; i <= NCH; i++) begin
            if (rd_idx == 7'(i)) begin
               if (rd_byte == `CADC_B_H) begin
                  rd_data[7:0] = sl_corr[i][15:8];
                  rd_resp = CADC_OKAY;
                  frz_c[i] = rd_acc;
               end else if (rd_byte == `CADC_B_L) begin
                  rd_data[7:0] = sl_corr_lo[i];
                  rd_resp = CADC_OKAY;
               end else if (i < NCH && rd_byte == `CADC_B_HU) begin
                  rd_data[7:0] = sl_raw[i][23:16];
                  rd_resp = CADC_OKAY;
                  frz_u[i] = rd_acc;
               end else if (i < NCH && rd_byte == `CADC_B_MU) begin
                  rd_data[7:0] = sl_raw_lo[i][15:8];
                  rd_resp = CADC_OKAY;
               end else if (i < NCH && rd_byte == `CADC_B_LU) begin
                  rd_data[7:0] = sl_raw_lo[i][7:0];
                  rd_resp = CADC_OKAY;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus and sequencer next state
   always_comb begin
      s_d = s_q;
      tmr_bus.load = 1'b0;
      tmr_bus.count = '0;
      s_d.go = 1'b0;
      s_d.start = 1'b0;
      s_d.abort = 1'b0;
      s_d.complete = 1'b0;
      if (i_axi_awvalid && s_q.awrdy) begin
         s_d.awfull = 1'b1;
         s_d.awaddr = i_axi_awaddr;
      end
      if (i_axi_wvalid && s_q.wrdy) begin
         s_d.wfull = 1'b1;
         s_d.wdata = i_axi_wdata;
         s_d.wstb0 = i_axi_wstrb[0];
      end
      if (s_q.bvalid && i_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         s_d.awfull = 1'b0;
         s_d.wfull = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = CADC_OKAY;
         if (s_q.awaddr[1:0] != 2'h0) begin
            s_d.bresp = CADC_SLVERR;
         end else if (s_q.awaddr == `CADC_OFF_TRIG) begin
            s_d.go = s_q.wstb0 && s_q.wdata[`CADC_TRIG_BIT];
         end else if (s_q.awaddr == `CADC_OFF_DELAY) begin
            if (s_q.wstb0) s_d.dly = s_q.wdata[7:0];
         end else if (s_q.awaddr == `CADC_OFF_SEQCFG) begin
            // Continuous bit stays writable; it takes effect at the next trigger, which stops a running sequence
            if (s_q.wstb0) s_d.cont = s_q.wdata[`CADC_CONT_BIT];
            if (s_q.wstb0 && !locked) s_d.intv = s_q.wdata[`CADC_INT_LSB +: 4];
         end else if (s_q.awaddr == `CADC_OFF_CHEN) begin
            if (s_q.wstb0 && !locked) s_d.chen = s_q.wdata[NCH-1:0];
         end else if (s_q.awaddr == `CADC_OFF_STATUS || s_q.awaddr == `CADC_OFF_COUNT) begin
            s_d.bresp = CADC_OKAY;
         end else if (s_q.awaddr >= `CADC_RES_BASE && s_q.awaddr < RES_END) begin
            s_d.bresp = CADC_OKAY;
         end else begin
            s_d.bresp = CADC_SLVERR;
         end
      end
      s_d.awrdy = !s_d.awfull;
      s_d.wrdy = !s_d.wfull;
      if (rd_acc) begin
         s_d.rvalid = 1'b1;
         s_d.arrdy = 1'b0;
         s_d.rdata = rd_data;
         s_d.rresp = rd_resp;
      end else if (s_q.rvalid && i_axi_rready) begin
         s_d.rvalid = 1'b0;
         s_d.arrdy = 1'b1;
      end else if (!s_q.rvalid) begin
         s_d.arrdy = 1'b1;
      end
      if (s_q.complete) s_d.ready = 1'b1;
      case (s_q.state)
         CADC_IDLE: begin
            s_d.busy = 1'b0;
         end
         CADC_DELAY: begin
            if (tmr_bus.done) begin
               s_d.start = 1'b1;
               s_d.busy = 1'b1;
               s_d.donem = '0;
               s_d.tdone = 1'b0;
               s_d.state = CADC_RUN;
            end
         end
         CADC_RUN: begin
            s_d.donem = donem_nx;
            s_d.tdone = s_q.tdone || i_temp_done;
            if (all_done) begin
               s_d.busy = 1'b0;
               s_d.complete = 1'b1;
               if (s_q.cont_run) begin
                  s_d.count = s_q.count + 14'h1;
                  s_d.state = CADC_WAIT;
                  tmr_bus.load = 1'b1;
                  tmr_bus.count = 16'({12'h000, s_q.intv}) * INT_CYC;
               end else begin
                  s_d.state = CADC_IDLE;
               end
            end
         end
         CADC_WAIT: begin
            if (tmr_bus.done) begin
               s_d.start = 1'b1;
               s_d.busy = 1'b1;
               s_d.donem = '0;
               s_d.tdone = 1'b0;
               s_d.state = CADC_RUN;
            end
         end
         default: begin
            s_d.state = CADC_IDLE;
         end
      endcase
      // A trigger wins over everything the sequencer was doing
      if (s_q.go) begin
         s_d.abort = (s_q.state != CADC_IDLE);
         s_d.ready = 1'b0;
         s_d.complete = 1'b0;
         s_d.busy = 1'b0;
         s_d.start = 1'b0;
         s_d.cont_run = s_q.cont;
         if (s_q.cont) s_d.count = '0;
         s_d.state = CADC_DELAY;
         tmr_bus.load = 1'b1;
         tmr_bus.count = 16'({8'h00, s_q.dly}) * DLY_CYC;
      end
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) s_q <= '0;
      else s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer and result slots
   cadc_timer u_timer (
      .i_clock (i_clock),
      .i_rst_n (rst_n),
      .bus     (tmr_bus.timer)
   );

   for (genvar g = 0; g <= NCH; g++) begin : g_slot
      logic wr_in;
      logic [23:0] raw_in;
      logic [15:0] cor_in;
      if (g < NCH) begin : g_cell
         // Stale done pulses from an aborted run are dropped outside RUN
         assign wr_in = i_ch_done[g] && s_q.chen[g] && s_q.state == CADC_RUN;
         assign raw_in = i_ch_raw[g*24 +: 24];
         assign cor_in = i_ch_corr[g*16 +: 16];
      end else begin : g_die
         assign wr_in = i_temp_done && s_q.state == CADC_RUN;
         assign raw_in = {{8{i_temp_raw[15]}}, i_temp_raw};
         assign cor_in = i_temp_raw;
      end
      cadc_result_slot #(.RAW_W(24), .COR_W(16)) u_slot (
         .i_clock   (i_clock),
         .i_rst_n   (rst_n),
         .i_preload (s_q.go),
         .i_wr      (wr_in),
         .i_raw     (raw_in),
         .i_corr    (cor_in),
         .i_frz_c   (frz_c[g]),
         .i_frz_u   (frz_u[g]),
         .o_raw     (sl_raw[g]),
         .o_corr    (sl_corr[g]),
         .o_raw_lo  (sl_raw_lo[g]),
         .o_corr_lo (sl_corr_lo[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_axi_awready = s_q.awrdy;
   assign o_axi_wready = s_q.wrdy;
   assign o_axi_bvalid = s_q.bvalid;
   assign o_axi_bresp = s_q.bresp;
   assign o_axi_arready = s_q.arrdy;
   assign o_axi_rvalid = s_q.rvalid;
   assign o_axi_rdata = s_q.rdata;
   assign o_axi_rresp = s_q.rresp;
   assign o_level_shift_en = s_q.chen;
   assign o_conv_start = s_q.start;
   assign o_conv_abort = s_q.abort;
   assign o_die_temp = sl_corr[NCH];

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_trig_pulse: assert property (s_q.go |=> !s_q.go) else $error("trigger longer than a cycle");
   a_go_clr_ready: assert property (s_q.go |=> !s_q.ready) else $error("ready survived trigger");
   a_start_delay: assert property (s_q.go && s_q.dly == 8'h00 |-> ##3 o_conv_start) else $error("zero delay start late");
   a_abort_on_go: assert property (s_q.go && s_q.state == CADC_RUN |=> o_conv_abort && s_q.state == CADC_DELAY) else $error("no abort");
   a_ready_after: assert property ($rose(s_q.ready) |-> $past(s_q.complete) && !s_q.busy) else $error("ready before results");
   a_busy_run: assert property (o_conv_start |-> s_q.busy && s_q.state == CADC_RUN) else $error("busy not set at start");
   a_count_step: assert property (s_q.state == CADC_RUN && all_done && s_q.cont_run && !s_q.go |=> s_q.count == $past(s_q.count) + 14'h1) else $error("counter missed");
   a_cont_restart: assert property (s_q.state == CADC_WAIT && tmr_bus.done && !s_q.go |=> o_conv_start) else $error("no restart");
   a_single_stop: assert property (s_q.state == CADC_RUN && all_done && !s_q.cont_run && !s_q.go |=> s_q.state == CADC_IDLE) else $error("kept running");
   a_cfg_locked: assert property (wr_fire && locked && s_q.awaddr == `CADC_OFF_CHEN |=> $stable(s_q.chen)) else $error("enable changed while running");
   a_ready_sticky: assert property (s_q.ready && !s_q.go |=> s_q.ready) else $error("ready dropped");
   a_cnt_clear: assert property (s_q.go && s_q.cont |=> s_q.count == 14'h0000) else $error("counter not cleared");
endmodule // cadc_top

/* tb/cadc_conv_model.sv */
// Purpose: converter stand-in for the cell conversion control
// Assumes: fixed latency from start to done
// Notes: a new start restarts the count; there is no abort input
`timescale 1ns/1ps
module cadc_conv_model #(parameter int LAT = 20) (
   input wire logic i_clock, // system clock
   input wire logic i_start, // start pulse
   input wire logic [5:0] i_en, // enabled channels
   output logic [5:0] o_done, // channel done pulses
   output logic o_tdone // die temperature done
);
   int cnt = 0;
   initial {o_done, o_tdone} = 7'h00;
   always @(posedge i_clock) begin
      cnt <= i_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
      o_done <= (cnt == 1) ? i_en : 6'h00;
      o_tdone <= (cnt == 1);
   end
endmodule // cadc_conv_model

/* tb/cadc_top_tb_top.sv */
// Purpose: self-checking bench of the cell conversion control
// Assumes: stand-in converter answers each start after 20 cycles
// Notes: byte reads return in rdata[7:0]
`timescale 1ns/1ps
`include "cadc_params.svh"
module cadc_top_tb_top;
   import cadc_pkg::*;
   logic i_clock = 0, i_rst_n = 0, i_axi_awvalid = 0, i_axi_wvalid = 0, i_axi_bready = 0;
   logic i_axi_arvalid = 0, i_axi_rready = 0, i_temp_done, o_conv_start, o_conv_abort;
   logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
   logic [11:0] i_axi_awaddr = 0, i_axi_araddr = 0;
   logic [31:0] i_axi_wdata = 0, o_axi_rdata, rd;
   logic [3:0] i_axi_wstrb = 4'hF;
   logic [143:0] i_ch_raw = 0;
   logic [95:0] i_ch_corr = 0;
   logic [15:0] i_temp_raw = 0, o_die_temp;
   logic [5:0] i_ch_done, o_level_shift_en, m;
   logic [1:0] o_axi_bresp, o_axi_rresp, rs;
   int fails = 0, total_checks = 0, seed = 1340, n, d, ns = 0, na = 0, n0;
   time ts, tw;
   cadc_top cadc_top_i (.i_clock, .i_rst_n, .i_axi_awvalid, .o_axi_awready, .i_axi_awaddr,
      .i_axi_wvalid, .o_axi_wready, .i_axi_wdata, .i_axi_wstrb, .o_axi_bvalid, .i_axi_bready,
      .o_axi_bresp, .i_axi_arvalid, .o_axi_arready, .i_axi_araddr, .o_axi_rvalid,
      .i_axi_rready, .o_axi_rdata, .o_axi_rresp, .i_ch_done, .i_ch_raw, .i_ch_corr,
      .i_temp_done, .i_temp_raw, .o_level_shift_en, .o_conv_start, .o_conv_abort, .o_die_temp);
   cadc_conv_model #(.LAT(20)) cadc_conv_model_i (.i_clock, .i_start(o_conv_start),
      .i_en(o_level_shift_en), .o_done(i_ch_done), .o_tdone(i_temp_done));
   always #20 i_clock = ~i_clock;
   // Starts and aborts are counted so a restart or a missed abort shows up
   always @(posedge i_clock) begin
      if (o_conv_start) begin
         ts = $time;
         ns++;
      end
      if (o_conv_abort) na++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task final_report;
      $display("fails %0d total_checks %0d", fails, total_checks);
      if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Every bus wait is bounded; running out ends the run as a failure
   task step;
      @(posedge i_clock);
      if (++n > 300) begin
         fails++;
         final_report;
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge i_clock);
      n = 0;
      {i_axi_awaddr, i_axi_wdata, i_axi_awvalid, i_axi_wvalid, i_axi_bready} <= {a, v, 3'h7};
      do begin
         step;
         if (o_axi_awready) i_axi_awvalid <= 0;
         if (o_axi_wready) i_axi_wvalid <= 0;
      end while (!o_axi_bvalid);
      rs = o_axi_bresp;
      i_axi_bready <= 0;
   endtask
   task rdr(input logic [11:0] a);
      @(posedge i_clock);
      n = 0;
      {i_axi_araddr, i_axi_arvalid, i_axi_rready} <= {a, 2'h3};
      do begin
         step;
         if (o_axi_arready) i_axi_arvalid <= 0;
      end while (!o_axi_rvalid);
      {rd, rs} = {o_axi_rdata, o_axi_rresp};
      i_axi_rready <= 0;
   endtask
   task wait_rdy;
      rd = 0;
      for (int k = 0; k < 100 && rd[1] !== 1'b1; k++) rdr(`CADC_OFF_STATUS);
      chk(32'(rd[1]), 32'h1);
      chk(32'(o_die_temp), 32'(i_temp_raw));
   endtask
   // Disabled channels keep the marker, since their done pulses are ignored
   function automatic logic [39:0] exp_slot(input int g);
      if (g == 6) return {i_temp_raw, {8{i_temp_raw[15]}}, i_temp_raw};
      if (!m[g]) return {16'h8000, 24'h800000};
      return {i_ch_corr[g*16+:16], i_ch_raw[g*24+:24]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge i_clock);
      i_rst_n <= 1;
      rdr(12'hFFC);
      chk(32'(rs), 32'(CADC_SLVERR));
      for (d = 0; d < 3; d++) begin
         m = 6'($random(seed)) | 6'h01;
         for (int g = 0; g < 6; g++) i_ch_raw[g*24+:24] <= 24'($random(seed));
         for (int g = 0; g < 6; g++) i_ch_corr[g*16+:16] <= 16'($random(seed));
         i_temp_raw <= 16'($random(seed));
         wr(`CADC_OFF_CHEN, 32'(m));
         chk(32'(o_level_shift_en), 32'(m));
         repeat (8) @(posedge i_clock);
         wr(`CADC_OFF_DELAY, d);
         tw = $time;
         wr(`CADC_OFF_TRIG, 32'h1);
         rdr(`CADC_RES_BASE);
         chk(rd, 32'h80);
         wait_rdy;
         chk(32'((ts - tw) / 40 - d * 25 inside {[2:10]}), 32'h1);
         for (int g = 0; g < 7; g++) for (int k = 0; k < (g == 6 ? 2 : 5); k++) begin
            rdr(12'(`CADC_RES_BASE + g * `CADC_RES_STRIDE + k * 4));
            chk(rd, 32'(exp_slot(g) >> (32 - k * 8)) & 32'hFF);
         end
         $display("on-demand round %0d done", d);
      end
      wr(`CADC_OFF_DELAY, 32'h0);
      wr(`CADC_OFF_SEQCFG, 32'h1);
      wr(`CADC_OFF_TRIG, 32'h1);
      wr(`CADC_OFF_CHEN, 32'(~m));
      chk(32'(o_level_shift_en), 32'(m));
      chk(32'(rs), 32'(CADC_OKAY));
      rd = 0;
      for (int k = 0; k < 100 && rd < 3; k++) rdr(`CADC_OFF_COUNT);
      chk(32'(rd >= 3), 32'h1);
      wait_rdy;
      for (int k = 0; k < 2; k++) begin
         rdr(12'(`CADC_RES_BASE + k * 4));
         chk(rd, 32'(exp_slot(0) >> (32 - k * 8)) & 32'hFF);
      end
      wr(`CADC_OFF_SEQCFG, 32'h0);
      wr(`CADC_OFF_TRIG, 32'h1);
      rdr(`CADC_OFF_STATUS);
      chk(32'(rd[1]), 32'h0);
      chk(32'(na), 32'h1);
      wait_rdy;
      rdr(`CADC_OFF_COUNT);
      d = rd;
      n0 = ns;
      for (int k = 0; k < 20; k++) rdr(`CADC_OFF_COUNT);
      chk(rd, 32'(d));
      chk(32'(ns), 32'(n0));
      $display("continuous run done");
      final_report;
   end
endmodule // cadc_top_tb_top
